// ===== core/vdd_pkg.sv
package vdd_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0]  REG_CTRL      = 8'h00;
	localparam logic [7:0]  REG_LIMIT     = 8'h04;
	localparam logic [7:0]  REG_CADENCE   = 8'h08;
	localparam logic [7:0]  REG_BASE      = 8'h0c;
	localparam logic [7:0]  REG_PITCH     = 8'h10;
	localparam logic [7:0]  REG_START     = 8'h14;
	localparam logic [7:0]  REG_STATUS    = 8'h18;
	localparam logic [7:0]  REG_NOISE     = 8'h1c;
	localparam logic [7:0]  REG_VAR_CUR   = 8'h20;
	localparam logic [7:0]  REG_VAR_PREV  = 8'h24;
	localparam int          CTRL_DN_BIT   = 0;
	localparam int          CTRL_DI_BIT   = 1;
	localparam int          CTRL_FIRST_BIT = 2;
	localparam int          CTRL_TOPF_BIT = 3;
	localparam int          CTRL_FMT_LSB  = 4;
	localparam int          CAD_PROG_BIT  = 0;
	localparam int          CAD_WEAVE_LSB = 1;
	localparam logic [7:0]  LIMIT_RST     = 8'h08;
	localparam logic [15:0] PITCH_RST     = 16'h0000;
	localparam logic [31:0] BASE_RST      = 32'h0000_0000;
	localparam logic [2:0]  CAD_RST       = 3'h0;
	// ----------------------------------------
	// timing and sizes
	// ----------------------------------------
	localparam logic [7:0]  BEATS_DI      = 8'h40;
	localparam logic [7:0]  BEATS_DN      = 8'h80;
	localparam logic [7:0]  MOTION_MAX    = 8'hff;
	localparam logic [3:0]  ANGLE_90      = 4'h4;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {FMT_420, FMT_411, FMT_422} vdd_fmt_t;
	typedef enum logic {ST_IDLE, ST_RUN} vdd_state_t;
	typedef struct packed {
		logic [7:0] u;
		logic [7:0] v;
	} vdd_uv_t;
	typedef struct packed {
		logic [11:0] x;
		logic [11:0] y;
		logic        last;
	} vdd_beat_t;
	typedef struct packed {
		logic [8:0][7:0] win;
		logic [7:0]      prev_luma;
		logic [7:0]      next_luma;
		vdd_uv_t         prev_uv;
		vdd_uv_t         next_uv;
		logic [8:0][7:0] above;
		logic [8:0][7:0] below;
		logic [3:0]      angle;
		vdd_uv_t [2:0]   c_above;
		vdd_uv_t [2:0]   c_below;
		vdd_uv_t         c_left;
		vdd_uv_t         c_right;
		logic            c_mid;
		logic [7:0]      motion_in;
		logic [7:0]      history_in;
	} vdd_win_t;
	typedef struct packed {
		logic [7:0] luma;
		vdd_uv_t    uv;
		logic [7:0] motion_out;
		logic [7:0] history_out;
		logic       field_bottom;
		logic       ref_next;
	} vdd_out_t;
	// ----------------------------------------
	// arithmetic helpers
	// ----------------------------------------
	function automatic logic [7:0] avg(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		avg = s[8:1];
	endfunction
	function automatic logic [7:0] absd(input logic [7:0] a, input logic [7:0] b);
		absd = (a > b) ? a - b : b - a;
	endfunction
	function automatic logic [7:0] blend(input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] m);
		logic [8:0]  w;
		logic [16:0] s;
		w = (m == MOTION_MAX) ? 9'h100 : {1'b0, m};
		s = 17'(a * w) + 17'(b * (9'h100 - w));
		blend = s[15:8];
	endfunction
endpackage

// ===== core/vdd_chroma_up.sv
`timescale 1ns/1ps
module vdd_chroma_up (
	// format and position
	input  wire vdd_pkg::vdd_fmt_t fmt,
	input  wire logic              c_mid,
	input  wire logic [11:0]       y,
	// source chroma
	input  wire vdd_pkg::vdd_uv_t  c_left,
	input  wire vdd_pkg::vdd_uv_t  c_right,
	// 4:2:2 result
	output vdd_pkg::vdd_uv_t       uv,
	output logic [11:0]            chroma_row
);
	// ----------------------------------------
	// up-sampling
	// ----------------------------------------
	always_comb begin
		uv = c_left;
		chroma_row = y;
		case (fmt)
			vdd_pkg::FMT_420: begin
				chroma_row = y >> 1; // [R8]
			end
			vdd_pkg::FMT_411: begin
				if (c_mid) begin
					uv.u = vdd_pkg::avg(c_left.u, c_right.u); // [R9]
					uv.v = vdd_pkg::avg(c_left.v, c_right.v); // [R9]
				end
			end
			default: begin
				uv = c_left; // [R7]
			end
		endcase
	end
endmodule

// ===== core/vdd_angle_interp.sv
`timescale 1ns/1ps
module vdd_angle_interp (
	// luma lines
	input  wire logic [8:0][7:0]       above,
	input  wire logic [8:0][7:0]       below,
	input  wire logic [3:0]            angle,
	// chroma lines: 0 vertical, 1 plus, 2 minus
	input  wire vdd_pkg::vdd_uv_t [2:0] c_above,
	input  wire vdd_pkg::vdd_uv_t [2:0] c_below,
	input  wire logic [7:0]            motion,
	// result
	output logic [7:0]                 luma,
	output vdd_pkg::vdd_uv_t           uv
);
	vdd_pkg::vdd_uv_t [2:0] s;
	vdd_pkg::vdd_uv_t       a;
	logic [3:0]             ang;
	// ----------------------------------------
	// interpolation
	// ----------------------------------------
	always_comb begin
		ang = (angle > 4'h8) ? vdd_pkg::ANGLE_90 : angle;
		luma = vdd_pkg::avg(above[ang], below[ang]); // [R6]
		for (int k = 0; k < 3; k++) begin
			s[k].u = vdd_pkg::avg(c_above[k].u, c_below[k].u);
			s[k].v = vdd_pkg::avg(c_above[k].v, c_below[k].v);
		end
		case (ang)
			4'h3: begin
				a.u = vdd_pkg::avg(s[0].u, s[2].u); // [R10]
				a.v = vdd_pkg::avg(s[0].v, s[2].v);
			end
			4'h5: begin
				a.u = vdd_pkg::avg(s[0].u, s[1].u); // [R10]
				a.v = vdd_pkg::avg(s[0].v, s[1].v);
			end
			4'h0, 4'h1, 4'h2: a = s[2]; // [R10]
			4'h6, 4'h7, 4'h8: a = s[1]; // [R10]
			default: a = s[0];
		endcase
		uv.u = vdd_pkg::blend(a.u, s[0].u, motion); // [R11]
		uv.v = vdd_pkg::blend(a.v, s[0].v, motion); // [R11]
	end
endmodule

// ===== core/vdd_core.sv
// Summary of operation
// (R1) temporal denoise weighted by 4x4 block history
// (R2) neighbour good when luma difference within limit
// (R3) block gradient over 3x3 current field
// (R4) motion blends temporal and spatial line fill
// (R5) first field uses previous, second next
// (R6) spatial average above and below along angle
// (R7) accept 420, 411, 422; emit 422
// (R8) 420 chroma doubled vertically by row reuse
// (R9) 411 new chroma averages left and right
// (R10) chroma angles reduced to 90 and 27
// (R11) chroma angle result blended toward vertical
// (R12) temporal fill averages previous and next fields
// (R13) progressive cadence weaves fields per lane bit
// (R14) cadence applied is one frame old
// (R15) variances summed per frame, software readable
// (R16) lane 0 prev second, lane 1 current first
// (R17) block pair done within 64 clocks; with deinterlace off a pair is 128 beats (BEATS_DN)
// (R18) statistics addresses from pixel position
// (R19) software ping-pongs statistics surfaces
// (R20) first frame: no history, full spatial, zero
// (R21) first frame: spatial only, motion writes 255
// (R22) first frame: previous variances max, interlaced
// (R23) block 16x4 with deinterlace, 16x8 otherwise
// (R24) reset returns everything to idle
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module vdd_core (
	// clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  reset,
	// register port
	input  wire logic [7:0]            reg_addr,
	input  wire logic [31:0]           reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic [31:0]                reg_rdata,
	// pixel input
	input  wire logic                  in_valid,
	output logic                       in_ready,
	input  wire vdd_pkg::vdd_beat_t    in_beat,
	input  wire vdd_pkg::vdd_win_t [1:0] in_win,
	// output to execution array
	output logic                       out_valid,
	input  wire logic                  out_ready,
	output vdd_pkg::vdd_out_t [1:0]    out_pix,
	output logic [1:0]                 out_lane_valid,
	output logic                       out_block_done,
	// statistics surface
	output logic                       history_rd_en,
	output logic                       motion_rd_en,
	output logic                       cadence_rd_en,
	output logic [31:0]                stat_base,
	output logic [15:0]                motion_column,
	output logic [15:0]                motion_row,
	output logic [15:0]                history_column,
	output logic [15:0]                history_row,
	output logic [11:0]                chroma_row
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	vdd_pkg::vdd_state_t state, next_state;
	logic                dn_en, next_dn_en;
	logic                di_en, next_di_en;
	logic                first, next_first;
	logic                top_first, next_top_first;
	vdd_pkg::vdd_fmt_t   fmt, next_fmt;
	logic [7:0]          limit, next_limit;
	logic [2:0]          cad_staged, next_cad_staged;
	logic [2:0]          cad_applied, next_cad_applied;
	logic [15:0]         pitch, next_pitch;
	logic [31:0]         next_stat_base;
	logic [31:0]         noise_sum, next_noise_sum;
	logic [31:0]         var_cur, next_var_cur;
	logic [31:0]         var_prev, next_var_prev;
	logic [7:0]          beat_cnt, next_beat_cnt;
	logic [31:0]         next_reg_rdata;
	logic                next_out_valid;
	vdd_pkg::vdd_out_t [1:0] next_out_pix;
	logic [1:0]          next_out_lane_valid;
	logic                next_out_block_done;
	logic [15:0]         next_motion_column, next_motion_row;
	logic [15:0]         next_history_column, next_history_row;
	logic [11:0]         next_chroma_row;
	vdd_pkg::vdd_out_t [1:0] lane_res;
	logic [1:0]          lane_act;
	logic [1:0][8:0]     lane_grad;
	logic [1:0][7:0]     lane_vcur, lane_vprev;
	logic [1:0][11:0]    lane_crow;
	logic                take, start, pair_end;
	logic [7:0]          blk_beats;

	// ----------------------------------------
	// lane datapath
	// ----------------------------------------
	function automatic logic [8:0] recip(input logic [3:0] n);
		case (n)
			4'h1: recip = 9'h100;
			4'h2: recip = 9'h080;
			4'h3: recip = 9'h055;
			4'h4: recip = 9'h040;
			4'h5: recip = 9'h033;
			4'h6: recip = 9'h02b;
			4'h7: recip = 9'h025;
			4'h8: recip = 9'h020;
			default: recip = 9'h01c;
		endcase
	endfunction

	genvar l;
	generate
		for (l = 0; l < 2; l++) begin : g_lane
			logic [7:0]       ang_luma, ctr, spat, temp, hw, mw, dn;
			vdd_pkg::vdd_uv_t ang_uv, up_uv, tuv;
			logic [11:0]      sum;
			logic [3:0]       cnt;
			logic [20:0]      prod;
			vdd_pkg::vdd_win_t w;
			assign w = in_win[l];
			assign mw = first ? vdd_pkg::MOTION_MAX : w.motion_in; // [R21]
			vdd_chroma_up u_up (
				.fmt        (fmt),
				.c_mid      (w.c_mid),
				.y          (in_beat.y),
				.c_left     (w.c_left),
				.c_right    (w.c_right),
				.uv         (up_uv),
				.chroma_row (lane_crow[l])
			);
			vdd_angle_interp u_ang (
				.above   (w.above),
				.below   (w.below),
				.angle   (w.angle),
				.c_above (w.c_above),
				.c_below (w.c_below),
				.motion  (mw),
				.luma    (ang_luma),
				.uv      (ang_uv)
			);
			always_comb begin
				ctr = w.win[4];
				sum = 12'h000;
				cnt = 4'h0;
				for (int k = 0; k < 9; k++) begin
					if (vdd_pkg::absd(w.win[k], ctr) <= limit) begin // [R2]
						sum = sum + {4'h0, w.win[k]};
						cnt = cnt + 4'h1;
					end
				end
				prod = 21'(sum * recip(cnt));
				spat = (prod[20:16] != 5'h00) ? 8'hff : prod[15:8];
				temp = vdd_pkg::avg(ctr, w.prev_luma);
				hw = first ? 8'h00 : w.history_in; // [R1] [R20]
				dn = dn_en ? vdd_pkg::blend(temp, spat, hw) : ctr;
				tuv.u = vdd_pkg::avg(w.prev_uv.u, w.next_uv.u); // [R12]
				tuv.v = vdd_pkg::avg(w.prev_uv.v, w.next_uv.v);
				lane_res[l].luma = vdd_pkg::blend(ang_luma,
					vdd_pkg::avg(w.prev_luma, w.next_luma), mw); // [R4] [R12]
				lane_res[l].uv.u = vdd_pkg::blend(ang_uv.u, tuv.u, mw); // [R4]
				lane_res[l].uv.v = vdd_pkg::blend(ang_uv.v, tuv.v, mw);
				if (cad_applied[vdd_pkg::CAD_PROG_BIT]) begin
					if (cad_applied[vdd_pkg::CAD_WEAVE_LSB + l]) begin // [R13]
						lane_res[l].luma = w.next_luma;
						lane_res[l].uv = w.next_uv;
					end else begin
						lane_res[l].luma = w.prev_luma;
						lane_res[l].uv = w.prev_uv;
					end
				end
				if (!di_en) begin
					lane_res[l].luma = dn;
					lane_res[l].uv = up_uv; // [R7]
				end
				lane_res[l].motion_out = first ? vdd_pkg::MOTION_MAX :
					vdd_pkg::absd(w.prev_luma, w.next_luma); // [R21]
				lane_res[l].history_out = first ? 8'h00 :
					vdd_pkg::absd(ctr, w.prev_luma); // [R20]
				lane_res[l].field_bottom = (l == 0) ? top_first : !top_first; // [R16]
				lane_res[l].ref_next = (l == 0); // [R5]
				lane_act[l] = (l == 0) ? (di_en && !first) : 1'b1; // [R21]
				lane_grad[l] = {1'b0, vdd_pkg::absd(w.win[5], w.win[3])} +
					{1'b0, vdd_pkg::absd(w.win[7], w.win[1])}; // [R3]
				lane_vcur[l] = vdd_pkg::absd(w.win[1], w.win[7]);
				lane_vprev[l] = first ? vdd_pkg::MOTION_MAX :
					vdd_pkg::absd(ctr, w.prev_luma); // [R22]
			end
		end
	endgenerate

	// ----------------------------------------
	// handshake and sequencing
	// ----------------------------------------
	assign in_ready = (state == vdd_pkg::ST_RUN) && (!out_valid || out_ready);
	assign take = in_valid && in_ready;
	assign start = reg_wr && (reg_addr == vdd_pkg::REG_START) &&
		(state == vdd_pkg::ST_IDLE);
	assign blk_beats = di_en ? vdd_pkg::BEATS_DI : vdd_pkg::BEATS_DN; // [R23]
	assign pair_end = take && (beat_cnt == blk_beats - 8'h01);
	assign history_rd_en = (state == vdd_pkg::ST_RUN) && dn_en && !first; // [R20]
	assign motion_rd_en = (state == vdd_pkg::ST_RUN) && di_en && !first; // [R21]
	assign cadence_rd_en = (state == vdd_pkg::ST_RUN) && !first; // [R22]

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	always_comb begin
		next_dn_en = dn_en;
		next_di_en = di_en;
		next_first = first;
		next_top_first = top_first;
		next_fmt = fmt;
		next_limit = limit;
		next_cad_staged = cad_staged;
		next_cad_applied = cad_applied;
		next_pitch = pitch;
		next_stat_base = stat_base;
		if (reg_wr && state == vdd_pkg::ST_IDLE) begin
			case (reg_addr)
				vdd_pkg::REG_CTRL: begin
					next_dn_en = reg_wdata[vdd_pkg::CTRL_DN_BIT];
					next_di_en = reg_wdata[vdd_pkg::CTRL_DI_BIT];
					next_first = reg_wdata[vdd_pkg::CTRL_FIRST_BIT];
					next_top_first = reg_wdata[vdd_pkg::CTRL_TOPF_BIT];
					next_fmt = vdd_pkg::vdd_fmt_t'(reg_wdata[vdd_pkg::CTRL_FMT_LSB +: 2]);
				end
				vdd_pkg::REG_LIMIT: next_limit = reg_wdata[7:0];
				vdd_pkg::REG_BASE: next_stat_base = reg_wdata;
				vdd_pkg::REG_PITCH: next_pitch = reg_wdata[15:0];
				default: next_pitch = pitch;
			endcase
		end
		if (reg_wr && reg_addr == vdd_pkg::REG_CADENCE) begin
			next_cad_staged = reg_wdata[2:0];
		end
		if (start) begin
			next_cad_applied = first ? 3'h0 : cad_staged; // [R14] [R22]
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			dn_en <= 1'b0; // [R24]
			di_en <= 1'b0;
			first <= 1'b0;
			top_first <= 1'b0;
			fmt <= vdd_pkg::FMT_420;
			limit <= vdd_pkg::LIMIT_RST;
			cad_staged <= vdd_pkg::CAD_RST;
			cad_applied <= vdd_pkg::CAD_RST;
			pitch <= vdd_pkg::PITCH_RST;
			stat_base <= vdd_pkg::BASE_RST;
		end else begin
			dn_en <= next_dn_en;
			di_en <= next_di_en;
			first <= next_first;
			top_first <= next_top_first;
			fmt <= next_fmt;
			limit <= next_limit;
			cad_staged <= next_cad_staged;
			cad_applied <= next_cad_applied;
			pitch <= next_pitch;
			stat_base <= next_stat_base;
		end
	end

	// ----------------------------------------
	// pipeline, statistics, readback
	// ----------------------------------------
	always_comb begin
		next_state = state;
		next_beat_cnt = beat_cnt;
		next_noise_sum = noise_sum;
		next_var_cur = var_cur;
		next_var_prev = var_prev;
		next_out_valid = out_valid && !out_ready;
		next_out_pix = out_pix;
		next_out_lane_valid = out_lane_valid;
		next_out_block_done = out_block_done && !out_ready;
		next_motion_column = motion_column;
		next_motion_row = motion_row;
		next_history_column = history_column;
		next_history_row = history_row;
		next_chroma_row = chroma_row;
		if (start) begin
			next_state = vdd_pkg::ST_RUN;
			next_beat_cnt = 8'h00;
			next_noise_sum = 32'h0000_0000;
			next_var_cur = 32'h0000_0000;
			next_var_prev = 32'h0000_0000;
		end
		if (take) begin
			next_out_valid = 1'b1;
			next_out_pix = lane_res;
			next_out_lane_valid = lane_act;
			next_out_block_done = pair_end; // [R17] [R23]
			next_beat_cnt = pair_end ? 8'h00 : beat_cnt + 8'h01;
			for (int k = 0; k < 2; k++) begin
				if (lane_act[k]) begin
					next_noise_sum = next_noise_sum + {23'h0, lane_grad[k]}; // [R3]
					next_var_cur = next_var_cur + {24'h0, lane_vcur[k]}; // [R15]
					next_var_prev = next_var_prev + {24'h0, lane_vprev[k]}; // [R15]
				end
			end
			next_motion_column = {5'h00, in_beat.x[11:1]}; // [R18]
			next_motion_row = {4'h0, in_beat.y};
			next_history_column = (pitch >> 1) + {6'h00, in_beat.x[11:2]}; // [R18]
			next_history_row = {6'h00, in_beat.y[11:2]};
			next_chroma_row = lane_crow[1]; // [R8]
			if (in_beat.last) begin
				next_state = vdd_pkg::ST_IDLE;
			end
		end
		next_reg_rdata = 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
				vdd_pkg::REG_CTRL: next_reg_rdata = {26'h0, fmt, top_first, first,
					di_en, dn_en};
				vdd_pkg::REG_LIMIT: next_reg_rdata = {24'h0, limit};
				vdd_pkg::REG_CADENCE: next_reg_rdata = {29'h0, cad_staged};
				vdd_pkg::REG_BASE: next_reg_rdata = stat_base;
				vdd_pkg::REG_PITCH: next_reg_rdata = {16'h0, pitch};
				vdd_pkg::REG_STATUS: next_reg_rdata = {20'h0, beat_cnt, cad_applied,
					state == vdd_pkg::ST_RUN};
				vdd_pkg::REG_NOISE: next_reg_rdata = noise_sum;
				vdd_pkg::REG_VAR_CUR: next_reg_rdata = var_cur; // [R15]
				vdd_pkg::REG_VAR_PREV: next_reg_rdata = var_prev; // [R15]
				default: next_reg_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state <= vdd_pkg::ST_IDLE; // [R24]
			beat_cnt <= 8'h00;
			noise_sum <= 32'h0000_0000;
			var_cur <= 32'h0000_0000;
			var_prev <= 32'h0000_0000;
			out_valid <= 1'b0;
			out_pix <= '0;
			out_lane_valid <= 2'h0;
			out_block_done <= 1'b0;
			motion_column <= 16'h0000;
			motion_row <= 16'h0000;
			history_column <= 16'h0000;
			history_row <= 16'h0000;
			chroma_row <= 12'h000;
			reg_rdata <= 32'h0000_0000;
		end else begin
			state <= next_state;
			beat_cnt <= next_beat_cnt;
			noise_sum <= next_noise_sum;
			var_cur <= next_var_cur;
			var_prev <= next_var_prev;
			out_valid <= next_out_valid;
			out_pix <= next_out_pix;
			out_lane_valid <= next_out_lane_valid;
			out_block_done <= next_out_block_done;
			motion_column <= next_motion_column;
			motion_row <= next_motion_row;
			history_column <= next_history_column;
			history_row <= next_history_row;
			chroma_row <= next_chroma_row;
			reg_rdata <= next_reg_rdata;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	logic [8:0] since_done;
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			since_done <= 9'h000;
		end else if (start || pair_end) begin
			since_done <= 9'h000;
		end else if (take) begin
			since_done <= since_done + 9'h001;
		end
	end
	a_pair_budget: assert property (di_en && state == vdd_pkg::ST_RUN |-> // [R17]
		since_done < 9'h040)
		else $error("block pair over budget");
	a_block_size: assert property (pair_end |-> since_done == {1'b0, blk_beats} - 9'h001) // [R23]
		else $error("block length wrong");
	a_hist_zero: assert property (take && first |=> out_pix[1].history_out == 8'h00) // [R20]
		else $error("first frame history not zero");
	a_motion_max: assert property (take && first |=> out_pix[1].motion_out == 8'hff) // [R21]
		else $error("first frame motion not max");
	a_lane0_off: assert property (take && first |=> !out_lane_valid[0]) // [R21]
		else $error("lane 0 active in first frame");
	a_no_hist_read: assert property (first |-> !history_rd_en && !motion_rd_en) // [R20]
		else $error("statistics read in first frame");
	a_cadence_lag: assert property (start && !first |=> cad_applied == $past(cad_staged)) // [R14]
		else $error("cadence not taken at frame start");
	a_cadence_first: assert property (start && first |=> cad_applied == 3'h0) // [R22]
		else $error("first frame not interlaced");
	a_motion_addr: assert property (take |=> motion_column == {5'h00, $past(in_beat.x[11:1])}
		&& history_row == {6'h00, $past(in_beat.y[11:2])}) // [R18]
		else $error("statistics address wrong");
	a_ref_lanes: assert property (out_valid |-> out_pix[0].ref_next && !out_pix[1].ref_next
		&& out_pix[0].field_bottom != out_pix[1].field_bottom) // [R5]
		else $error("reference selection wrong");
	c_first_frame: cover property (start && first ##[64:200] pair_end);
	c_progressive: cover property (take && cad_applied[0]);
	c_dn_only: cover property (pair_end && !di_en);
	c_stall: cover property (out_valid && !out_ready ##1 out_valid && out_ready);
endmodule

// ===== tb/vdd_sink.sv
`timescale 1ns/1ps
module vdd_sink (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic reset,
	// flow control
	input  wire logic stall,
	output logic      out_ready
);
	logic [2:0] cnt;
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			cnt <= 3'h0;
		else
			cnt <= cnt + 3'h1;
	end
	// holds off two cycles in eight when stalling
	assign out_ready = !reset && !(stall && cnt[2:1] == 2'h3);
endmodule

// ===== tb/tb_video_denoise_deinterlacer.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("ERROR %s exp %h got %h", n, e, g); end end
module tb_video_denoise_deinterlacer;
	typedef struct packed {
		logic [7:0]  l;
		logic [15:0] c;
		logic [7:0]  m, h;
		logic [1:0]  v;
		logic        d;
		logic [15:0] mx, my, hx, hy;
		logic [3:0]  f;
		logic [11:0] cr;
	} vdd_exp_t;
	logic                    ref_clk, reset, reg_wr, reg_rd, in_valid, in_ready, stall;
	logic                    out_valid, out_ready, done, hrd, mrd, crd;
	logic [7:0]              reg_addr;
	logic [31:0]             reg_wdata, reg_rdata, seed, base, ctrl;
	logic [15:0]             pitch, mcol, mrow, hcol, hrow;
	logic [1:0]              lanes;
	logic [3:0]              flds;
	logic [11:0]             crow;
	vdd_pkg::vdd_beat_t      in_beat;
	vdd_pkg::vdd_win_t [1:0] in_win;
	vdd_pkg::vdd_out_t [1:0] out_pix;
	vdd_exp_t                ex;
	vdd_exp_t                exp_q[$];
	int                      mismatches, total_checks;
	vdd_core i_dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.in_valid(in_valid), .in_ready(in_ready), .in_beat(in_beat), .in_win(in_win),
		.out_valid(out_valid), .out_ready(out_ready), .out_pix(out_pix),
		.out_lane_valid(lanes), .out_block_done(done), .history_rd_en(hrd),
		.motion_rd_en(mrd), .cadence_rd_en(crd), .stat_base(base), .motion_column(mcol),
		.motion_row(mrow), .history_column(hcol), .history_row(hrow), .chroma_row(crow));
	vdd_sink i_sink (.ref_clk(ref_clk), .reset(reset), .stall(stall), .out_ready(out_ready));
	assign flds = {out_pix[0].field_bottom, out_pix[0].ref_next,
		out_pix[1].field_bottom, out_pix[1].ref_next};
	always #5 ref_clk = ~ref_clk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] av(input logic [7:0] a, input logic [7:0] b);
		return 8'((9'(a) + 9'(b)) >> 1);
	endfunction
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
		`CHK("rdata", e, reg_rdata & m)
	endtask
	task automatic beat(input int n, input logic first, input logic last);
		logic [31:0]       r;
		logic [11:0]       x, y;
		logic              di, dn;
		vdd_pkg::vdd_win_t w;
		vdd_exp_t          e;
		int                k;
		r = rnd();
		x = 12'(rnd());
		y = 12'(rnd());
		di = ctrl[vdd_pkg::CTRL_DI_BIT];
		dn = ctrl[vdd_pkg::CTRL_DN_BIT];
		w = '0;
		w.win = {9{r[7:0] ^ 8'h80}};
		w.win[4] = r[7:0];
		w.c_left = r[15:0];
		w.c_right = r[31:16];
		w.c_mid = 1'b1;
		w.prev_luma = r[15:8];
		w.next_luma = r[15:8];
		w.angle = 4'(r[31:24] % 9);
		w.c_above = {3{r[15:0]}};
		w.c_below = {3{r[31:16]}};
		w.prev_uv = {av(r[15:8], r[31:24]), av(r[7:0], r[23:16])};
		w.next_uv = w.prev_uv;
		w.above = {rnd(), rnd(), 8'(rnd())};
		w.below = {rnd(), rnd(), 8'(rnd())};
		w.motion_in = first ? r[23:16] : 8'h00;
		e.l = !di ? r[7:0] : first ? av(w.above[w.angle], w.below[w.angle]) : w.prev_luma;
		e.c = w.prev_uv;
		e.m = first ? 8'hff : 8'h00;
		e.h = first ? 8'h00 : (r[7:0] > r[15:8] ? r[7:0] - r[15:8] : r[15:8] - r[7:0]);
		e.v = (first || !di) ? 2'b10 : 2'b11;
		e.d = ((n + 1) % (di ? vdd_pkg::BEATS_DI : vdd_pkg::BEATS_DN)) == 0;
		e.f = {ctrl[vdd_pkg::CTRL_TOPF_BIT], 1'b1, !ctrl[vdd_pkg::CTRL_TOPF_BIT], 1'b0};
		e.cr = (ctrl[vdd_pkg::CTRL_FMT_LSB +: 2] == 2'h0) ? (y >> 1) : y;
		e.mx = 16'(x >> 1);
		e.my = 16'(y);
		e.hx = (pitch >> 1) + 16'(x >> 2);
		e.hy = 16'(y >> 2);
		in_valid <= 1'b1;
		in_beat <= '{x: x, y: y, last: last};
		in_win <= {w, w};
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (in_ready !== 1'b1 && k < 50);
		if (k >= 50) begin
			mismatches++;
			report_and_stop();
		end
		exp_q.push_back(e);
		`CHK("rd_en", {dn && !first, di && !first, !first}, {hrd, mrd, crd})
	endtask
	task automatic frame(input int nb, input logic first);
		for (int n = 0; n < nb; n++)
			beat(n, first, n == nb - 1);
		in_valid <= 1'b0;
		for (int k = 0; k < 400 && exp_q.size() > 0; k++)
			@(posedge ref_clk);
		`CHK("drained", 0, exp_q.size())
		$display("frame of %0d beats done", nb);
	endtask
	always @(posedge ref_clk) begin
		if (out_valid === 1'b1 && out_ready === 1'b1) begin
			ex = exp_q.pop_front();
			for (int i = 0; i < 2; i++) begin
				if (ex.v[i]) begin
					`CHK("luma", ex.l, out_pix[i].luma)
					`CHK("uv", ex.c, out_pix[i].uv)
					`CHK("motion", ex.m, out_pix[i].motion_out)
					`CHK("history", ex.h, out_pix[i].history_out)
				end
			end
			`CHK("lanes", ex.v, lanes)
			`CHK("block_done", ex.d, done)
			`CHK("stat", {ex.mx, ex.my, ex.hx, ex.hy}, {mcol, mrow, hcol, hrow})
			`CHK("fields", ex.f, flds)
			`CHK("crow", ex.cr, crow)
		end
	end
	initial begin
		ref_clk = 0;
		reset = 1;
		{reg_wr, reg_rd, in_valid, stall} = '0;
		reg_addr = '0;
		reg_wdata = '0;
		in_beat = '0;
		in_win = '0;
		seed = 32'h44383404;
		pitch = 16'h0140;
		repeat (5) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		rd(vdd_pkg::REG_LIMIT, 32'h08, '1);
		rd(vdd_pkg::REG_STATUS, 32'h0, '1);
		rd(8'h30, 32'h0, '1);
		wr(vdd_pkg::REG_PITCH, 32'(pitch));
		wr(vdd_pkg::REG_BASE, 32'h00ab_1200);
		ctrl = 32'h07;
		wr(vdd_pkg::REG_CTRL, ctrl);
		wr(vdd_pkg::REG_CADENCE, 32'h6);
		wr(vdd_pkg::REG_START, 32'h1);
		wr(vdd_pkg::REG_LIMIT, 32'h55);
		rd(vdd_pkg::REG_STATUS, 32'h1, 32'hf);
		`CHK("base", 32'h00ab_1200, base)
		frame(64, 1'b1);
		rd(vdd_pkg::REG_LIMIT, 32'h08, '1);
		rd(vdd_pkg::REG_VAR_PREV, 32'h3fc0, '1);
		ctrl = 32'h2b;
		wr(vdd_pkg::REG_CTRL, ctrl);
		wr(vdd_pkg::REG_START, 32'h1);
		rd(vdd_pkg::REG_STATUS, 32'hd, 32'hf);
		stall <= 1'b1;
		frame(128, 1'b0);
		wr(vdd_pkg::REG_BASE, 32'h00ab_2200);
		wr(vdd_pkg::REG_CADENCE, 32'h7);
		wr(vdd_pkg::REG_START, 32'h1);
		rd(vdd_pkg::REG_STATUS, 32'hf, 32'hf);
		frame(64, 1'b0);
		ctrl = 32'h11;
		wr(vdd_pkg::REG_CTRL, ctrl);
		wr(vdd_pkg::REG_START, 32'h1);
		frame(128, 1'b0);
		report_and_stop();
	end
endmodule
